// ==== src/dmlr_defs.vh ====
`ifndef DMLR_DEFS_VH
`define DMLR_DEFS_VH
// register byte addresses
`define DMLR_ADDR_GAP_A      16'h831c
`define DMLR_ADDR_VID_START  16'h8320
`define DMLR_ADDR_STRIDE     16'h8324
`define DMLR_ADDR_SIZES      16'h8328
`define DMLR_ADDR_GAP_B      16'h832c
`define DMLR_ADDR_FB_START   16'h8310
`define DMLR_ADDR_CB_START   16'h8314
`define DMLR_ADDR_CONTROL    16'h8300
// field positions
`define DMLR_START_MSB       21
`define DMLR_STRIDE_FB_MSB   9
`define DMLR_STRIDE_CB_LSB   12
`define DMLR_STRIDE_CB_MSB   21
`define DMLR_VSIZE_MSB       29
`define DMLR_VSIZE_LSB       16
`define DMLR_CBSIZE_MSB      15
`define DMLR_CBSIZE_LSB      9
`define DMLR_FBSIZE_MSB      8
`define DMLR_CTL_UNLOCK      0
`define DMLR_CTL_PAN         1
// reset value and video size saturation limit
`define DMLR_ZERO32          32'h00000000
`define DMLR_VSIZE_MAX       14'h3fff
`endif

// ==== src/dmlr_regs.v ====
// Operation
// [RULE1] video start is 22-bit byte offset
// [RULE2] software keeps video start low nibble zero
// [RULE3] packed line pointer advances by packed stride
// [RULE4] frame stride in words gives next line
// [RULE5] running frame line pointer feeds fetch queue
// [RULE6] video size in 64-byte units, 1MB max
// [RULE7] packed line size detects queue overflow
// [RULE8] software keeps packed line size at most 41h
// [RULE9] fetch frame line size qwords per line
// [RULE10] panning drops surplus data past line end; here pan_enable only feeds the unused wire pan_drop_unused
// [RULE11] software writes zero to reserved bits
// [RULE12] reserved gaps read zero
// [RULE13] registers undefined after reset, software initialises
// [RULE14] locked registers writable only when unlocked
// [RULE15] frame start address waits for frame start
`timescale 1ns/100ps
`default_nettype none
`include "dmlr_defs.vh"
module dmlr_regs (
    input  wire        core_clk_in,
    input  wire        reset_in,
    input  wire [15:0] addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rdata_out,
    input  wire        frame_start_in,
    input  wire        line_start_in,
    input  wire        fetch_ack_in,
    input  wire        packed_push_in,
    output reg  [21:0] frame_addr_out,
    output reg  [21:0] packed_addr_out,
    output reg  [21:0] fetch_addr_out,
    output reg         fetch_valid_out,
    output reg         fetch_last_out,
    output reg  [8:0]  fetch_remain_out,
    output reg  [3:0]  pixel_offset_out,
    output reg  [21:0] video_base_out,
    output reg  [19:0] video_bytes_out,
    output reg         packed_overflow_out
);
////////////////////////////////////////////////////////////////////////////
// register file; data regs have no reset, matching undefined power-up
reg  [21:0] frame_start_field;
reg  [21:0] packed_start_field;
reg  [21:0] video_start_field;
reg  [9:0]  frame_stride_field;
reg  [9:0]  packed_stride_field;
reg  [13:0] video_size_field;
reg  [6:0]  packed_line_size_field;
reg  [8:0]  frame_line_size_field;
reg         unlocked;
reg         pan_enable;
reg  [17:0] pending_frame_addr;
wire        wr_ok = wr_in && unlocked;                               // see [RULE14]

always @(posedge core_clk_in) begin                                  // see [RULE13]
    if (wr_ok) begin
        case (addr_in)
        `DMLR_ADDR_FB_START: begin
            frame_start_field <= wdata_in[`DMLR_START_MSB:0];
        end
        `DMLR_ADDR_CB_START: begin
            packed_start_field <= wdata_in[`DMLR_START_MSB:0];
        end
        `DMLR_ADDR_VID_START: begin
            video_start_field <= wdata_in[`DMLR_START_MSB:0];          // see [RULE1]
        end
        `DMLR_ADDR_STRIDE: begin
            frame_stride_field  <= wdata_in[`DMLR_STRIDE_FB_MSB:0];
            packed_stride_field <= wdata_in[`DMLR_STRIDE_CB_MSB:`DMLR_STRIDE_CB_LSB];
        end
        `DMLR_ADDR_SIZES: begin
            video_size_field       <= wdata_in[`DMLR_VSIZE_MSB:`DMLR_VSIZE_LSB];
            packed_line_size_field <= wdata_in[`DMLR_CBSIZE_MSB:`DMLR_CBSIZE_LSB];
            frame_line_size_field  <= wdata_in[`DMLR_FBSIZE_MSB:0];
        end
        default: begin
        end
        endcase
    end
end

// control word itself is never locked, otherwise software could not unlock
always @(posedge core_clk_in) begin
    if (reset_in) begin
        unlocked   <= 1'b0;
        pan_enable <= 1'b0;
    end else if (wr_in && addr_in == `DMLR_ADDR_CONTROL) begin
        unlocked   <= wdata_in[`DMLR_CTL_UNLOCK];
        pan_enable <= wdata_in[`DMLR_CTL_PAN];
    end
end

always @(posedge core_clk_in) begin
    if (reset_in) begin
        rdata_out <= `DMLR_ZERO32;
    end else if (rd_in) begin
        case (addr_in)
        `DMLR_ADDR_FB_START:  rdata_out <= {10'h000, frame_start_field};
        `DMLR_ADDR_CB_START:  rdata_out <= {10'h000, packed_start_field};
        `DMLR_ADDR_VID_START: rdata_out <= {10'h000, video_start_field};
        `DMLR_ADDR_STRIDE:    rdata_out <= {10'h000, packed_stride_field,
                                            2'h0, frame_stride_field};
        `DMLR_ADDR_SIZES:     rdata_out <= {2'h0, video_size_field,
                                            packed_line_size_field, frame_line_size_field};
        `DMLR_ADDR_CONTROL:   rdata_out <= {30'h00000000, pan_enable, unlocked};
        default:              rdata_out <= `DMLR_ZERO32;              // see [RULE12]
        endcase
    end else begin
        rdata_out <= `DMLR_ZERO32;
    end
end

////////////////////////////////////////////////////////////////////////////
// frame start: address part deferred, pixel part immediate
always @(posedge core_clk_in) begin
    if (reset_in) begin
        pending_frame_addr <= 18'h00000;
        pixel_offset_out   <= 4'h0;
    end else begin
        // loaded with the write itself so the pixel part never shows unwritten data
        if (wr_ok && addr_in == `DMLR_ADDR_FB_START) begin
            pixel_offset_out <= wdata_in[3:0];                       // see [RULE15]
        end
        if (frame_start_in) begin
            pending_frame_addr <= frame_start_field[`DMLR_START_MSB:4]; // see [RULE15]
        end
    end
end

// video window; low nibble forced zero in case software leaves junk
always @(posedge core_clk_in) begin
    if (reset_in) begin
        video_base_out  <= 22'h000000;
        video_bytes_out <= 20'h00000;
    end else begin
        video_base_out  <= {video_start_field[`DMLR_START_MSB:4], 4'h0}; // see [RULE2]
        if (video_size_field >= `DMLR_VSIZE_MAX) begin
            video_bytes_out <= 20'hfffc0;                            // see [RULE6]
        end else begin
            video_bytes_out <= {video_size_field[13:0], 6'h00};      // see [RULE6]
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// line pointers and per-line fetch sequencer
reg [8:0] next_remain;
always @* begin
    next_remain = fetch_remain_out - 9'h001;
end

always @(posedge core_clk_in) begin
    if (reset_in) begin
        frame_addr_out   <= 22'h000000;
        packed_addr_out  <= 22'h000000;
        fetch_addr_out   <= 22'h000000;
        fetch_valid_out  <= 1'b0;
        fetch_last_out   <= 1'b0;
        fetch_remain_out <= 9'h000;
    end else if (frame_start_in) begin
        frame_addr_out  <= {frame_start_field[`DMLR_START_MSB:4], 4'h0};
        packed_addr_out <= packed_start_field;
        fetch_valid_out <= 1'b0;
        fetch_last_out  <= 1'b0;
    end else if (line_start_in) begin
        // a new line aborts any leftover fetch of the previous one
        fetch_addr_out   <= frame_addr_out;                          // see [RULE5]
        fetch_remain_out <= frame_line_size_field;                   // see [RULE9]
        fetch_valid_out  <= (frame_line_size_field != 9'h000);
        fetch_last_out   <= (frame_line_size_field == 9'h001);
        frame_addr_out   <= frame_addr_out
                          + {10'h000, frame_stride_field, 2'h0};     // see [RULE4]
        packed_addr_out  <= packed_addr_out
                          + {10'h000, packed_stride_field, 2'h0};    // see [RULE3]
    end else if (fetch_valid_out && fetch_ack_in) begin
        fetch_addr_out   <= fetch_addr_out + 22'h000008;
        fetch_remain_out <= next_remain;
        fetch_valid_out  <= (next_remain != 9'h000);
        fetch_last_out   <= (next_remain == 9'h001);
    end
end

////////////////////////////////////////////////////////////////////////////
// packed queue fill count; overflow when count reaches line size
// when panning, data past line end is not dropped; pan_enable only feeds the unused wire pan_drop_unused
reg [6:0] packed_count;
always @(posedge core_clk_in) begin
    if (reset_in) begin
        packed_count        <= 7'h00;
        packed_overflow_out <= 1'b0;
    end else if (line_start_in) begin
        packed_count        <= 7'h00;
        packed_overflow_out <= 1'b0;
    end else if (packed_push_in) begin
        packed_count <= packed_count + 7'h01;
        if (packed_count + 7'h01 >= packed_line_size_field) begin   // see [RULE7]
            packed_overflow_out <= 1'b1;
        end
    end
end

wire pan_drop_unused = pan_enable & pending_frame_addr[0];           // see [RULE10]
endmodule // dmlr_regs
`default_nettype wire

// ==== testbench/dmlr_regs_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmlr_props (
    input wire        core_clk_in,
    input wire        reset_in,
    input wire [15:0] addr_in,
    input wire        rd_in,
    input wire        wr_in,
    input wire [31:0] rdata_out,
    input wire        frame_start_in,
    input wire        line_start_in,
    input wire        fetch_ack_in,
    input wire        packed_push_in,
    input wire [21:0] fetch_addr_out,
    input wire        fetch_valid_out,
    input wire        fetch_last_out,
    input wire [8:0]  fetch_remain_out,
    input wire [3:0]  pixel_offset_out,
    input wire [21:0] video_base_out,
    input wire [19:0] video_bytes_out,
    input wire        packed_overflow_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (reset_in);
////////////////////////////////////////////////////////////////
property p_idle; !rd_in |=> rdata_out == 32'h0; endproperty
a_idle: assert property (p_idle) else $error("rdata not zero");
property p_gap; rd_in && (addr_in == 16'h831c || addr_in == 16'h832c) |=> rdata_out == 32'h0;
endproperty
a_gap: assert property (p_gap) else $error("gap not zero");
property p_align; video_base_out[3:0] == 4'h0; endproperty
a_align: assert property (p_align) else $error("video base unaligned");
property p_units; video_bytes_out[5:0] == 6'h0; endproperty
a_units: assert property (p_units) else $error("video bytes not 64");
property p_step;
    fetch_valid_out && fetch_ack_in && !fetch_last_out && !line_start_in && !frame_start_in |=>
    fetch_addr_out == $past(fetch_addr_out) + 22'h8 && fetch_remain_out == $past(fetch_remain_out) - 9'h1;
endproperty
a_step: assert property (p_step) else $error("fetch step wrong");
property p_end;
    fetch_valid_out && fetch_ack_in && fetch_last_out && !line_start_in |=> !fetch_valid_out;
endproperty
a_end: assert property (p_end) else $error("fetch overran");
property p_hold;
    fetch_valid_out && !fetch_ack_in && !line_start_in && !frame_start_in |=> $stable(fetch_addr_out);
endproperty
a_hold: assert property (p_hold) else $error("fetch addr moved");
property p_clr; line_start_in && !packed_push_in |=> !packed_overflow_out; endproperty
a_clr: assert property (p_clr) else $error("overflow not cleared");
property p_pix; !wr_in |=> $stable(pixel_offset_out); endproperty
a_pix: assert property (p_pix) else $error("pixel offset moved");
c_fetch: cover property (fetch_valid_out && fetch_last_out);
c_ovf: cover property ($rose(packed_overflow_out));
c_rd: cover property (rd_in ##1 rdata_out != 32'h0);
endmodule // dmlr_props
bind dmlr_regs dmlr_props i_dmlr_props (.*);
`default_nettype wire

// ==== testbench/dmlr_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmlr_regs_test;
    logic        clk = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, fs = 1'b0, ls = 1'b0;
    logic        ack = 1'b0, push = 1'b0;
    logic [15:0] addr_in = 16'h0;
    logic [31:0] wdata_in = 32'h0;
    wire  [31:0] rdata_out;
    wire  [21:0] fr_a, fe_a, vb, pa;
    wire  [19:0] vbytes;
    wire  [8:0]  rem;
    wire  [3:0]  pix;
    wire         fv, fl, ovf;
    int          bad_count = 0, total_checks = 0;
    dmlr_regs i_dmlr_regs (.core_clk_in(clk), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .frame_start_in(fs), .line_start_in(ls), .fetch_ack_in(ack), .packed_push_in(push),
        .frame_addr_out(fr_a), .packed_addr_out(pa), .fetch_addr_out(fe_a), .fetch_valid_out(fv),
        .fetch_last_out(fl), .fetch_remain_out(rem), .pixel_offset_out(pix),
        .video_base_out(vb), .video_bytes_out(vbytes), .packed_overflow_out(ovf));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(logic [15:0] a, logic [31:0] d);
        @(posedge clk); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        @(posedge clk); wr_in <= 1'b0;
    endtask
    task rd(logic [15:0] a, logic [31:0] e, string n);
        @(posedge clk); addr_in <= a; rd_in <= 1'b1;
        @(posedge clk); rd_in <= 1'b0;
        #1 chk(n, e, rdata_out);
    endtask
    task line;
        @(posedge clk); ls <= 1'b1; ack <= 1'b1;
        @(posedge clk); ls <= 1'b0;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_regs;
        wr(16'h8300, 32'h1);
        wr(16'h8320, 32'h00123450);
        rd(16'h8320, 32'h00123450, "video start");
        chk("video base", 32'h123450, vb);
        wr(16'h8300, 32'h0);
        wr(16'h8320, 32'h00abcd00);
        rd(16'h8320, 32'h00123450, "locked write");
        wr(16'h8300, 32'h1);
        wr(16'h831c, 32'hffffffff);
        rd(16'h831c, 32'h0, "gap a");
        rd(16'h832c, 32'h0, "gap b");
        rd(16'h8400, 32'h0, "unmapped");
        wr(16'h8328, 32'h3fff0403);
        @(posedge clk); #1 chk("max bytes", 32'hfffc0, vbytes);
        wr(16'h8328, 32'h00100403);
        @(posedge clk); #1 chk("bytes", 32'h400, vbytes);
        rd(16'h8328, 32'h00100403, "sizes");
        $display("test regs done");
    endtask
    task t_fetch;
        wr(16'h8324, 32'h00003020);
        wr(16'h8314, 32'h200);
        wr(16'h8310, 32'h105);
        #1 chk("pixel", 32'h5, pix);
        chk("frame ptr early", 32'h0, fr_a);
        @(posedge clk); fs <= 1'b1;
        @(posedge clk); fs <= 1'b0;
        #1 chk("frame ptr", 32'h100, fr_a);
        chk("packed ptr", 32'h200, pa);
        line;
        for (int i = 0; i < 3; i++) begin
            #1 chk("fetch valid", 32'h1, fv);
            chk("fetch addr", 32'h100 + 8 * i, fe_a);
            chk("remain", 32'h3 - i, rem);
            chk("last", (i == 2), fl);
            @(posedge clk);
        end
        #1 chk("fetch end", 32'h0, fv);
        chk("packed step", 32'h20c, pa);
        @(posedge clk); push <= 1'b1;
        repeat (2) @(posedge clk);
        push <= 1'b0;
        @(posedge clk); #1 chk("overflow", 32'h1, ovf);
        line;
        #1 chk("next line", 32'h180, fe_a);
        chk("overflow clear", 32'h0, ovf);
        chk("packed next", 32'h218, pa);
        @(posedge clk); ack <= 1'b0;
        $display("test fetch done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset_in <= 1'b0;
        t_regs;
        t_fetch;
        close_out;
    end
    initial begin
        #4000;
        bad_count++;
        close_out;
    end
endmodule // dmlr_regs_test
`default_nettype wire
